// [verilog/slpc_map.svh]
// Constants for the synthesizer latch bank and power control.
// Assumes inclusion by bare name from the package and the top module.
`ifndef SLPC_MAP_SVH
`define SLPC_MAP_SVH

// -----------------------------------------------------------------
// Word and field sizes
// -----------------------------------------------------------------
`define SLPC_WORD_W     24
`define SLPC_SEL_W      2
`define SLPC_B_W        13
`define SLPC_A_W        5
`define SLPC_R_W        14
`define SLPC_MON_W      3

// -----------------------------------------------------------------
// Latch select codes (low two bits of the word)
// -----------------------------------------------------------------
`define SLPC_SEL_CTRL   2'h0
`define SLPC_SEL_REF    2'h1
`define SLPC_SEL_FB     2'h2
`define SLPC_SEL_TEST   2'h3

// -----------------------------------------------------------------
// Reset values and timing counts
// -----------------------------------------------------------------
`define SLPC_WORD_RST   24'h000000
`define SLPC_PWR_RST    6'h3c
`define SLPC_SYNC_EDGES 2
`define SLPC_EDGE_CNT_W 2

// -----------------------------------------------------------------
// Monitor output select codes
// -----------------------------------------------------------------
`define SLPC_MON_LOW    3'h0
`define SLPC_MON_LOCK   3'h1
`define SLPC_MON_REF    3'h2
`define SLPC_MON_PWR    3'h3
`define SLPC_MON_BAND   3'h4
`define SLPC_MON_HIGH   3'h7

`endif

// [verilog/slpc_pkg.sv]
// Types for the synthesizer latch bank and power control.
// Assumes slpc_map.svh sits on the include path.
`include "slpc_map.svh"

package slpc_pkg;

  // -----------------------------------------------------------------
  // Latch layouts, most significant field first
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]             prescaler_sel;        // prescaler_sel_hi/lo
    logic                   powerdown_sync_select;
    logic                   powerdown_request;
    logic [2:0]             pump_current_two;     // from pump_current_two_bit0
    logic [2:0]             pump_current_one;     // from pump_current_one_bit0
    logic [1:0]             output_power;         // output_power_hi/lo
    logic                   mute_until_locked;
    logic                   pump_gain_select;
    logic                   pump_highz;
    logic                   detector_polarity;
    logic [`SLPC_MON_W-1:0] monitor_sel;
    logic                   counter_reset;
    logic [1:0]             core_power;
    logic [`SLPC_SEL_W-1:0] latch_select;
  } slpc_ctrl_t;

  typedef struct packed {
    logic                   prescaler_from_halved;
    logic                   output_halving;
    logic                   pump_gain_select;
    logic [`SLPC_B_W-1:0]   b_count;
    logic                   reserved_bit;
    logic [`SLPC_A_W-1:0]   a_count;
    logic [`SLPC_SEL_W-1:0] latch_select;
  } slpc_fb_t;

  typedef struct packed {
    logic [1:0]             reserved_bits;
    logic [1:0]             band_clock_divider;   // band_clock_divider_hi/lo
    logic                   factory_test_bit;
    logic                   lock_count_precision;
    logic [1:0]             antibacklash_width;   // antibacklash_width_hi/lo
    logic [`SLPC_R_W-1:0]   ref_count;
    logic [`SLPC_SEL_W-1:0] latch_select;
  } slpc_ref_t;

  // Power-down status bundle
  typedef struct packed {
    logic powered_down;
    logic counters_load;
    logic pump_tristate;
    logic lock_detect_clear;
    logic ref_buffer_enable;
    logic rf_output_enable;
  } slpc_pwr_t;

  typedef enum logic [1:0] {PS_OFF, PS_ON, PS_SYNC_WAIT, PS_DOWN} slpc_state_t;

endpackage

// [verilog/slpc_latch_power.sv]
// Serial latch bank and power-down control of the synthesizer.
// Assumes a host that writes 24-bit words on link_clk and strobes
// load_strobe while link_clk stands still; analog blocks outside.
//
// How it works
// - Shift 24 bits MSB first, load on strobe
// - Low two bits pick destination latch
// - Select 00 loads control latch
// - Select 10 loads feedback-divider latch
// - Control write with request clear powers up; feedback starts band
// - Feedback write while up starts band search, changed or not; writes while down share one at power-up
// - Request bit alone powers down at once
// - Synchronous mode waits two reference edges
// - Chip enable low disables immediately
// - Power-down forces counters to load state
// - Power-down tristates pump, clears lock detect
// - Power-down kills reference buffer and outputs
// - Serial register keeps working while down
// - Top control bits select prescaler
// - Two three-bit pump current settings
// - Gain bit picks current setting two
// - Mute outputs until lock when enabled
// - Pump high-impedance bit tristates pump
// - One bit sets detector polarity
// - Two bits set output power
// - Three bits select monitor output
`timescale 1ns/1ps
`include "slpc_map.svh"

module slpc_latch_power
  import slpc_pkg::*;
#(
  parameter int WORD_W     = `SLPC_WORD_W,
  parameter int SYNC_EDGES = `SLPC_SYNC_EDGES
)(
  input  wire logic       clk,                 // Core clock, 250 MHz
  input  wire logic       reset_n,             // Async reset, active low
  input  wire logic       link_clk,            // Serial clock from host
  input  wire logic       serial_data,         // Serial data, link domain
  input  wire logic       load_strobe,         // Latch strobe pin
  input  wire logic       chip_enable,         // Chip enable pin
  input  wire logic       ref_div_out,         // Reference divider output
  input  wire logic       lock_detect_in,      // Digital lock detect
  output slpc_ctrl_t      ctrl_word,           // Control latch
  output slpc_ref_t       ref_word,            // Reference-divider latch
  output slpc_fb_t        fb_word,             // Feedback-divider latch
  output logic            pump_gain,           // Latest pump gain select
  output slpc_pwr_t       pwr,                 // Power-down effects
  output logic            band_select_start,   // One-cycle band search
  output logic            monitor_output_pin   // Monitor output
);

  // -----------------------------------------------------------------
  // Parameter checks
  // -----------------------------------------------------------------
  if (WORD_W != `SLPC_WORD_W)
  begin : g_bad_width
    $error("slpc_latch_power: word width must be 24");
  end
  if (SYNC_EDGES < 1 || SYNC_EDGES > (1 << `SLPC_EDGE_CNT_W))
  begin : g_bad_edges
    $error("slpc_latch_power: SYNC_EDGES out of range");
  end

  // -----------------------------------------------------------------
  // Link domain: serial input register
  // -----------------------------------------------------------------
  logic [WORD_W-1:0] shift_reg;
  logic [WORD_W-1:0] shift_next;

  // Shift in MSB first; never gated by power state
  always_comb
  begin
    shift_next = {shift_reg[WORD_W-2:0], serial_data};
  end

  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
      shift_reg <= `SLPC_WORD_RST;
    else
      shift_reg <= shift_next;
  end

  // -----------------------------------------------------------------
  // Pin synchronisers into the core domain
  // -----------------------------------------------------------------
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync1_next;
  logic [3:0] sync2_next;
  logic       strobe_d_reg;
  logic       ref_d_reg;
  logic       strobe_d_next;
  logic       ref_d_next;

  // Bit order: strobe, chip enable, reference output, lock detect
  always_comb
  begin
    sync1_next    = {load_strobe, chip_enable, ref_div_out, lock_detect_in};
    sync2_next    = sync1_reg;
    strobe_d_next = sync2_reg[3];
    ref_d_next    = sync2_reg[1];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_reg    <= 4'h0;
      sync2_reg    <= 4'h0;
      strobe_d_reg <= 1'b0;
      ref_d_reg    <= 1'b0;
    end
    else
    begin
      sync1_reg    <= sync1_next;
      sync2_reg    <= sync2_next;
      strobe_d_reg <= strobe_d_next;
      ref_d_reg    <= ref_d_next;
    end
  end

  logic strobe_rise;
  logic ref_rise;
  logic ce_low;
  logic locked;

  // Edge detect on second stage only
  assign strobe_rise = sync2_reg[3] & ~strobe_d_reg;
  assign ref_rise    = sync2_reg[1] & ~ref_d_reg;
  assign ce_low      = ~sync2_reg[2];
  assign locked      = sync2_reg[0];

  // -----------------------------------------------------------------
  // Latch decode
  // -----------------------------------------------------------------
  // Word crosses as quasi-static data: the host holds link_clk still
  // while the strobe is high, so shift_reg is stable when sampled.
  function automatic logic sel_is(input logic [WORD_W-1:0] w,
                                  input logic [`SLPC_SEL_W-1:0] code);
    sel_is = (w[`SLPC_SEL_W-1:0] == code);
  endfunction

  logic wr_ctrl;
  logic wr_ref;
  logic wr_fb;

  assign wr_ctrl = strobe_rise & sel_is(shift_reg, `SLPC_SEL_CTRL);
  assign wr_ref  = strobe_rise & sel_is(shift_reg, `SLPC_SEL_REF);
  assign wr_fb   = strobe_rise & sel_is(shift_reg, `SLPC_SEL_FB);

  // -----------------------------------------------------------------
  // Latch registers
  // -----------------------------------------------------------------
  slpc_ctrl_t ctrl_reg;
  slpc_ctrl_t ctrl_next;
  slpc_ref_t  ref_reg;
  slpc_ref_t  ref_next;
  slpc_fb_t   fb_reg;
  slpc_fb_t   fb_next;
  logic       gain_reg;
  logic       gain_next;

  // Test latch words are dropped; test mode is factory only
  always_comb
  begin
    ctrl_next = ctrl_reg;
    ref_next  = ref_reg;
    fb_next   = fb_reg;
    gain_next = gain_reg;
    if (wr_ctrl)
    begin
      ctrl_next = slpc_ctrl_t'(shift_reg);
      gain_next = ctrl_next.pump_gain_select;
    end
    if (wr_ref)
      ref_next = slpc_ref_t'(shift_reg);
    if (wr_fb)
    begin
      fb_next   = slpc_fb_t'(shift_reg);
      gain_next = fb_next.pump_gain_select;     // Last writer wins
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_reg <= slpc_ctrl_t'(`SLPC_WORD_RST);
      ref_reg  <= slpc_ref_t'(`SLPC_WORD_RST);
      fb_reg   <= slpc_fb_t'(`SLPC_WORD_RST);
      gain_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      ref_reg  <= ref_next;
      fb_reg   <= fb_next;
      gain_reg <= gain_next;
    end
  end

  assign ctrl_word = ctrl_reg;
  assign ref_word  = ref_reg;
  assign fb_word   = fb_reg;
  assign pump_gain = gain_reg;

  // -----------------------------------------------------------------
  // Power state machine
  // -----------------------------------------------------------------
  slpc_state_t                 state_reg;
  slpc_state_t                 state_next;
  logic [`SLPC_EDGE_CNT_W-1:0] edge_cnt_reg;
  logic [`SLPC_EDGE_CNT_W-1:0] edge_cnt_next;

  // Starts off; first control write powers up unless it asks otherwise
  always_comb
  begin
    state_next    = state_reg;
    edge_cnt_next = edge_cnt_reg;
    case (state_reg)
      PS_SYNC_WAIT:
      begin
        if (ref_rise)
        begin
          if (edge_cnt_reg == SYNC_EDGES[`SLPC_EDGE_CNT_W-1:0] - 1'b1)
            state_next = PS_DOWN;
          else
            edge_cnt_next = edge_cnt_reg + 1'b1;
        end
      end
      PS_OFF, PS_ON, PS_DOWN:
      begin
        state_next = state_reg;
      end
      default:
      begin
        state_next = PS_OFF;
      end
    endcase
    // A new control word overrides any wait in progress
    if (wr_ctrl)
    begin
      edge_cnt_next = '0;
      if (!ctrl_next.powerdown_request)
        state_next = PS_ON;
      else if (!ctrl_next.powerdown_sync_select)
        state_next = PS_DOWN;
      else if (state_reg == PS_ON || state_reg == PS_SYNC_WAIT)
        state_next = PS_SYNC_WAIT;
      else
        state_next = state_reg;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg    <= PS_OFF;
      edge_cnt_reg <= '0;
    end
    else
    begin
      state_reg    <= state_next;
      edge_cnt_reg <= edge_cnt_next;
    end
  end

  logic pd_now;

  // Chip enable overrides the programmed bits
  assign pd_now = ce_low
                | (state_next == PS_OFF) | (state_next == PS_DOWN);

  // -----------------------------------------------------------------
  // Band select trigger
  // -----------------------------------------------------------------
  logic band_pend_reg;
  logic band_pend_next;
  logic band_start_reg;
  logic band_start_next;

  // Search only on a feedback write; a write while down waits for power
  always_comb
  begin
    band_start_next = ~pd_now & (wr_fb | band_pend_reg);
    if (wr_fb & pd_now)
      band_pend_next = 1'b1;
    else if (~pd_now)
      band_pend_next = 1'b0;
    else
      band_pend_next = band_pend_reg;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      band_pend_reg  <= 1'b0;
      band_start_reg <= 1'b0;
    end
    else
    begin
      band_pend_reg  <= band_pend_next;
      band_start_reg <= band_start_next;
    end
  end

  assign band_select_start = band_start_reg;

  // -----------------------------------------------------------------
  // Power-down effects and analog controls
  // -----------------------------------------------------------------
  slpc_pwr_t pwr_reg;
  slpc_pwr_t pwr_next;

  // All outputs registered; they follow pd_now one cycle later
  always_comb
  begin
    pwr_next.powered_down      = pd_now;
    pwr_next.counters_load     = pd_now | ctrl_next.counter_reset;
    pwr_next.pump_tristate     = pd_now | ctrl_next.pump_highz;
    pwr_next.lock_detect_clear = pd_now;
    pwr_next.ref_buffer_enable = ~pd_now;
    // Muted outputs wait for lock; lock is a synchronised level
    pwr_next.rf_output_enable  = ~pd_now
                               & (~ctrl_next.mute_until_locked | locked);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pwr_reg <= slpc_pwr_t'(`SLPC_PWR_RST); // Reset looks powered down, like the off state
    else
      pwr_reg <= pwr_next;
  end

  assign pwr = pwr_reg;

  // -----------------------------------------------------------------
  // Monitor output select
  // -----------------------------------------------------------------
  logic mon_reg;
  logic mon_next;

  // Polarity bit lives in ctrl_word.detector_polarity for the pump
  always_comb
  begin
    case (ctrl_next.monitor_sel)
      `SLPC_MON_LOW:  mon_next = 1'b0;
      `SLPC_MON_LOCK: mon_next = locked & ~pd_now;
      `SLPC_MON_REF:  mon_next = sync2_reg[1];
      `SLPC_MON_PWR:  mon_next = pd_now;
      `SLPC_MON_BAND: mon_next = band_start_next;
      `SLPC_MON_HIGH: mon_next = 1'b1;
      default:        mon_next = ctrl_next.detector_polarity;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      mon_reg <= 1'b0;
    else
      mon_reg <= mon_next;
  end

  assign monitor_output_pin = mon_reg;

endmodule

// [tb/slpc_latch_power_chk.sv]
// Assertion checker for the latch bank and power control.
// Assumes a bind onto slpc_latch_power; sees its ports only.
`timescale 1ns/1ps
module slpc_latch_power_chk
  import slpc_pkg::*;
#(
  parameter int WORD_W     = 24,
  parameter int SYNC_EDGES = 2
)(
  input wire logic       clk,                // Core clock
  input wire logic       reset_n,            // Async reset
  input wire logic       link_clk,           // Serial clock
  input wire logic       serial_data,        // Serial data
  input wire logic       load_strobe,        // Latch strobe
  input wire logic       chip_enable,        // Chip enable
  input wire logic       ref_div_out,        // Reference output
  input wire logic       lock_detect_in,     // Lock level
  input wire slpc_ctrl_t ctrl_word,          // Control latch
  input wire slpc_ref_t  ref_word,           // Reference latch
  input wire slpc_fb_t   fb_word,            // Feedback latch
  input wire logic       pump_gain,          // Gain select
  input wire slpc_pwr_t  pwr,                // Power effects
  input wire logic       band_select_start,  // Band pulse
  input wire logic       monitor_output_pin  // Monitor pin
);
  // ----
  // Properties
  // ----
  // One domain, so clock and reset are given once
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_pd_counters: assert property (pwr.powered_down |-> pwr.counters_load)
    else $error("counters free while down");
  chk_pd_pump: assert property (pwr.powered_down |-> pwr.pump_tristate && pwr.lock_detect_clear)
    else $error("pump or lock live while down");
  chk_pd_outputs: assert property (pwr.powered_down |-> !pwr.ref_buffer_enable && !pwr.rf_output_enable)
    else $error("buffer or outputs on while down");
  chk_ce_override: assert property ((!chip_enable) [*5] |-> pwr.powered_down)
    else $error("chip enable low ignored");
  chk_async_down: assert property ($changed(ctrl_word) && ctrl_word.powerdown_request
    && !ctrl_word.powerdown_sync_select |-> pwr.powered_down) else $error("async down late");
  chk_sync_down: assert property ($changed(ctrl_word) && ctrl_word.powerdown_request
    && ctrl_word.powerdown_sync_select && !pwr.powered_down
    |=> !pwr.powered_down ##[1:200] pwr.powered_down) else $error("sync down timing");
  chk_power_up: assert property (chip_enable [*6] ##0 ($changed(ctrl_word)
    && !ctrl_word.powerdown_request) |-> !pwr.powered_down) else $error("no power-up");
  chk_up_pump: assert property (!pwr.powered_down |->
    pwr.pump_tristate == ctrl_word.pump_highz && pwr.ref_buffer_enable) else $error("pump state wrong");
  chk_mute_lock: assert property ((!lock_detect_in) [*4] ##0 ctrl_word.mute_until_locked
    |-> !pwr.rf_output_enable) else $error("output on before lock");
  chk_fb_band: assert property ($changed(fb_word) && !pwr.powered_down |-> band_select_start)
    else $error("no band search");
  chk_gain_ctrl: assert property ($changed(ctrl_word) |-> pump_gain == ctrl_word.pump_gain_select)
    else $error("gain not from control");
  chk_mon_power: assert property (ctrl_word.monitor_sel == 3'h3
    |-> monitor_output_pin == pwr.powered_down) else $error("monitor wrong");

  // Main scenarios reached
  cover property ($rose(pwr.powered_down));
  cover property (band_select_start);
  cover property (ctrl_word.powerdown_sync_select && $rose(pwr.powered_down));
endmodule

// [tb/slpc_host_model.sv]
// Host model driving the three-wire programming link.
// Assumes the device shifts on rising link clock edges.
`timescale 1ns/1ps
module slpc_host_model (
  output logic link_clk,     // Serial clock, still between frames
  output logic serial_data,  // Serial data, MSB first
  output logic load_strobe   // Latch strobe
);
  initial
  begin
    link_clk = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b0;
  end

  // ----
  // Frame: 24 bits, then strobe with the clock held still
  // ----
  task automatic send(input logic [23:0] v);
    for (int i = 23; i >= 0; i--)
    begin
      serial_data = v[i];
      #15 link_clk = 1'b1;
      #15 link_clk = 1'b0;
    end
    // Released data line shows the inverse, not the last bit
    #5 serial_data = ~v[0];
    #10 load_strobe = 1'b1;
    #40 load_strobe = 1'b0;
    #20;
  endtask
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the latch bank and power control.
// Assumes design, checker and host model compile before it.
`timescale 1ns/1ps
`include "slpc_map.svh"
module tb_top
  import slpc_pkg::*;
;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        chip_enable = 1'b1;
  logic        ref_div_out = 1'b0;
  logic        lock_detect_in = 1'b0;
  logic        link_clk, serial_data, load_strobe;
  logic        pump_gain, band_select_start, monitor_output_pin;
  slpc_ctrl_t  ctrl_word, c;
  slpc_ref_t   ref_word;
  slpc_fb_t    fb_word;
  slpc_pwr_t   pwr;
  logic [23:0] w, k0, k1, k2;
  logic [31:0] seed = 32'h59;
  logic [2:0]  mons [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  int          failures = 0;
  int          check_count = 0;
  int          bands = 0;
  int          b0;

  always #2 clk = ~clk;

  // ----
  // Device and host
  // ----
  slpc_latch_power i_slpc_latch_power (
    .clk(clk), .reset_n(reset_n), .link_clk(link_clk), .serial_data(serial_data),
    .load_strobe(load_strobe), .chip_enable(chip_enable), .ref_div_out(ref_div_out),
    .lock_detect_in(lock_detect_in), .ctrl_word(ctrl_word), .ref_word(ref_word),
    .fb_word(fb_word), .pump_gain(pump_gain), .pwr(pwr),
    .band_select_start(band_select_start), .monitor_output_pin(monitor_output_pin));
  slpc_host_model i_slpc_host_model (
    .link_clk(link_clk), .serial_data(serial_data), .load_strobe(load_strobe));

  // Count band searches; a pulse lasts one cycle only
  always @(posedge clk)
    if (band_select_start === 1'b1)
      bands <= bands + 1;

  // ----
  // Helpers
  // ----
  function automatic logic [23:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[23:0];
  endfunction

  // Lock-clear bit is masked: its level while up is open
  function automatic logic [23:0] exp_pwr(input logic dn, input slpc_ctrl_t k, input logic lk);
    if (dn)
      return 24'h38;
    return {18'h0, 1'b0, k.counter_reset, k.pump_highz, 1'b0, 1'b1, !k.mute_until_locked | lk};
  endfunction

  function automatic slpc_ctrl_t mk_ctrl(input logic [1:0] pd, input logic mute, input logic [2:0] mon);
    slpc_ctrl_t k;
    k = rnd();
    k.powerdown_sync_select = pd[1];
    k.powerdown_request = pd[0];
    k.mute_until_locked = mute;
    k.monitor_sel = mon;
    k.latch_select = `SLPC_SEL_CTRL;
    return k;
  endfunction

  task automatic cmp_word(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t word %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t bit %b exp %b", $time, got, exp);
    end
  endtask

  // Latch lands 2..3 cycles after the strobe rises
  task automatic put(input logic [23:0] v);
    i_slpc_host_model.send(v);
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic ref_pulse();
    @(posedge clk);
    ref_div_out <= 1'b1;
    repeat (4) @(posedge clk);
    ref_div_out <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic fb_write();
    w = rnd();
    w[1:0] = `SLPC_SEL_FB;
    b0 = bands;
    put(w);
    cmp_word(fb_word, w);
    cmp_bit(pump_gain, w[21]);
    cmp_word(bands[23:0], b0[23:0] + 24'h1);
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge clk);
    failures++;
    end_of_test();
  end

  // ----
  // Main sequence
  // ----
  initial
  begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    cmp_word({18'h0, pwr}, 24'h3c);
    w = rnd();
    w[1:0] = `SLPC_SEL_REF;
    put(w);
    cmp_word(ref_word, w);
    cmp_bit(pwr.powered_down, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      c = mk_ctrl(2'h0, 1'b0, mons[i]);
      put(c);
      cmp_word(ctrl_word, c);
      cmp_word({18'h0, pwr & 6'h3b}, exp_pwr(1'b0, c, 1'b0));
      cmp_bit(pump_gain, c.pump_gain_select);
      cmp_bit(monitor_output_pin, mons[i] == 3'h7);
    end
    // Settling gap scaled down; the block keeps no timer for it
    repeat (50) @(posedge clk);
    fb_write();
    k0 = ctrl_word;
    k1 = ref_word;
    k2 = fb_word;
    w = rnd();
    w[1:0] = `SLPC_SEL_TEST;
    put(w);
    cmp_word(ctrl_word, k0);
    cmp_word(ref_word, k1);
    cmp_word(fb_word, k2);
    c = mk_ctrl(2'h1, 1'b0, 3'h3);
    put(c);
    cmp_word({18'h0, pwr & 6'h3b}, exp_pwr(1'b1, c, 1'b0));
    cmp_bit(monitor_output_pin, 1'b1);
    b0 = bands;
    c = mk_ctrl(2'h0, 1'b0, 3'h0);
    put(c);
    cmp_bit(pwr.powered_down, 1'b0);
    cmp_bit(bands == b0, 1'b1);
    c = mk_ctrl(2'h3, 1'b0, 3'h0);
    put(c);
    ref_pulse();
    cmp_bit(pwr.powered_down, 1'b0);
    ref_pulse();
    cmp_bit(pwr.powered_down, 1'b1);
    c = mk_ctrl(2'h0, 1'b1, 3'h0);
    put(c);
    cmp_bit(pwr.rf_output_enable, 1'b0);
    @(posedge clk);
    lock_detect_in <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    cmp_bit(pwr.rf_output_enable, 1'b1);
    @(posedge clk);
    chip_enable <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    cmp_word({18'h0, pwr & 6'h3b}, exp_pwr(1'b1, c, 1'b1));
    w = rnd();
    w[1:0] = `SLPC_SEL_REF;
    put(w);
    cmp_word(ref_word, w);
    @(posedge clk);
    chip_enable <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    cmp_word({18'h0, pwr & 6'h3b}, exp_pwr(1'b0, c, 1'b1));
    // Random traffic; request bit kept clear so feedback writes meet a live device
    for (int i = 0; i < 8; i++)
    begin
      w = rnd();
      if (w[0])
        fb_write();
      else
      begin
        w[1:0] = {1'b0, w[2]};
        w[20] = 1'b0;
        put(w);
        cmp_word(w[0] ? {ref_word} : {ctrl_word}, w);
      end
    end
    end_of_test();
  end
endmodule

bind slpc_latch_power slpc_latch_power_chk #(.WORD_W(WORD_W), .SYNC_EDGES(SYNC_EDGES)) i_slpc_latch_power_chk (
  .clk(clk), .reset_n(reset_n), .link_clk(link_clk), .serial_data(serial_data),
  .load_strobe(load_strobe), .chip_enable(chip_enable), .ref_div_out(ref_div_out),
  .lock_detect_in(lock_detect_in), .ctrl_word(ctrl_word), .ref_word(ref_word),
  .fb_word(fb_word), .pump_gain(pump_gain), .pwr(pwr),
  .band_select_start(band_select_start), .monitor_output_pin(monitor_output_pin));
